// *** rtl/hcr_params.svh ***
// constants for the host-controller identity, reset and dma set-up registers
`ifndef HCR_PARAMS_SVH
`define HCR_PARAMS_SVH
`define HCR_OFS_IDENTITY  16'h0304
`define HCR_OFS_SCRATCH   16'h0308
`define HCR_OFS_SWRESET   16'h030c
`define HCR_OFS_DMACFG    16'h0330
`define HCR_RST_WORD      32'h0000_0000
`define HCR_RST_COUNT     24'h00_0000
`define HCR_RST_BURST     2'h0
`define HCR_SWR_ALL_BIT   0
`define HCR_SWR_HC_BIT    1
`define HCR_CFG_CNT_HI    31
`define HCR_CFG_CNT_LO    8
`define HCR_CFG_BURST_HI  3
`define HCR_CFG_BURST_LO  2
`define HCR_CFG_EN_BIT    1
`define HCR_CFG_DIR_BIT   0
`define HCR_BURST_1       2'h0
`define HCR_BURST_4       2'h1
`define HCR_BURST_8       2'h2
`define HCR_BURST_16      2'h3
`define HCR_BEATS_1       5'h01
`define HCR_BEATS_4       5'h04
`define HCR_BEATS_8       5'h08
`define HCR_BEATS_16      5'h10
`define HCR_BEAT_ZERO     5'h00
`define HCR_BEAT_ONE      5'h01
`define HCR_GAP_LAST      5'h02
`define HCR_STEP_16       24'h00_0002
`define HCR_STEP_32       24'h00_0004
// arbitrary identity values
`define HCR_HW_VERSION    16'h0002
`define HCR_DEVICE_ID     16'h5a3c
`endif

// *** rtl/hcr_pkg.sv ***
// types shared by the register bank and the dma engine
`default_nettype none
package hcr_pkg;
   typedef enum logic [2:0] {
      hcr_st_idle = 3'b001,
      hcr_st_req  = 3'b010,
      hcr_st_gap  = 3'b100
   } hcr_dma_state_t;

   typedef struct packed {
      hcr_dma_state_t state;
      logic [23:0]    remaining;
      logic [4:0]     beat;
      logic           ack_meta;
      logic           ack_sync;
      logic           req_line;
      logic           busy;
   } hcr_dma_t;

   typedef struct packed {
      logic [31:0] scratch;
      logic [23:0] count;
      logic [1:0]  burst;
      logic        en;
      logic        dir;
      logic        hc_pulse;
      logic        all_pulse;
      logic        start;
      logic [31:0] rdata;
   } hcr_regs_t;
endpackage : hcr_pkg
`default_nettype wire

// *** rtl/hcr_dma_engine.sv ***
// slave dma request engine: byte counting, bursts, handshake polarity
`timescale 1ns/1ps
`default_nettype none
`include "hcr_params.svh"
module hcr_dma_engine (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // set-up from the register bank
   input  wire logic        soft_clear_i,
   input  wire logic        start_i,
   input  wire logic        enable_i,
   input  wire logic [23:0] byte_count_i,
   input  wire logic [1:0]  burst_sel_i,
   input  wire logic        bus_width_32_i,
   input  wire logic        request_polarity_i,
   input  wire logic        acknowledge_polarity_i,
   // handshake pins
   input  wire logic        transfer_ack_line_i,
   output logic             transfer_request_line_o,
   // status
   output logic             busy_o
);
   hcr_pkg::hcr_dma_t r;
   hcr_pkg::hcr_dma_t next_r;
   logic [4:0]        beats;
   logic [23:0]       step;
   logic              ack_seen;

   always_comb begin
      next_r = r;
      case (burst_sel_i)
         `HCR_BURST_4:  beats = `HCR_BEATS_4;
         `HCR_BURST_8:  beats = `HCR_BEATS_8;
         `HCR_BURST_16: beats = `HCR_BEATS_16;
         default:       beats = `HCR_BEATS_1;
      endcase
      step = bus_width_32_i ? `HCR_STEP_32 : `HCR_STEP_16;
      ack_seen = (r.ack_sync == acknowledge_polarity_i);
      next_r.ack_meta = transfer_ack_line_i;
      next_r.ack_sync = r.ack_meta;
      case (r.state)
         hcr_pkg::hcr_st_idle: begin
            if (start_i && enable_i && byte_count_i != `HCR_RST_COUNT) begin
               next_r.state     = hcr_pkg::hcr_st_req;
               next_r.remaining = byte_count_i;
               next_r.beat      = `HCR_BEAT_ZERO;
            end
         end
         hcr_pkg::hcr_st_req: begin
            if (ack_seen) begin
               if (r.remaining <= step) begin
                  next_r.remaining = `HCR_RST_COUNT;
                  next_r.state     = hcr_pkg::hcr_st_idle;
               end else begin
                  next_r.remaining = r.remaining - step;
                  if (r.beat == beats - `HCR_BEAT_ONE) begin
                     next_r.beat  = `HCR_BEAT_ZERO;
                     next_r.state = hcr_pkg::hcr_st_gap;
                  end else begin
                     next_r.beat = r.beat + `HCR_BEAT_ONE;
                  end
               end
            end
         end
         hcr_pkg::hcr_st_gap: begin
            // gap outlasts the ack synchroniser so stale acks are not counted
            if (r.beat == `HCR_GAP_LAST) begin
               next_r.beat  = `HCR_BEAT_ZERO;
               next_r.state = hcr_pkg::hcr_st_req;
            end else begin
               next_r.beat = r.beat + `HCR_BEAT_ONE;
            end
         end
         default: next_r.state = hcr_pkg::hcr_st_idle;
      endcase
      if (!enable_i || soft_clear_i) begin
         next_r.state     = hcr_pkg::hcr_st_idle;
         next_r.remaining = `HCR_RST_COUNT;
         next_r.beat      = `HCR_BEAT_ZERO;
      end
      next_r.busy     = (next_r.state != hcr_pkg::hcr_st_idle);
      next_r.req_line = (next_r.state == hcr_pkg::hcr_st_req) ? request_polarity_i
                                                               : ~request_polarity_i;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         r          <= '{state: hcr_pkg::hcr_st_idle, default: '0};
         r.req_line <= ~request_polarity_i;
      end else begin
         r <= next_r;
      end
   end

   assign transfer_request_line_o = r.req_line;
   assign busy_o                  = r.busy;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   chk_idle_req_off: assert property (
      !next_r.busy ##1 $stable(request_polarity_i)
      |-> transfer_request_line_o != request_polarity_i)
      else $error("request line active while idle");
   chk_term_abandon: assert property (
      !enable_i |=> !busy_o && r.state == hcr_pkg::hcr_st_idle)
      else $error("transfer not abandoned on terminate");
   chk_count_step: assert property (
      enable_i && !soft_clear_i && r.state == hcr_pkg::hcr_st_req && ack_seen
      && r.remaining > step |=> r.remaining == $past(r.remaining) - $past(step))
      else $error("byte count step wrong");
   chk_burst_end: assert property (
      enable_i && !soft_clear_i && r.state == hcr_pkg::hcr_st_req && ack_seen
      && r.remaining > step && r.beat == beats - `HCR_BEAT_ONE |=> r.state == hcr_pkg::hcr_st_gap)
      else $error("burst did not end at programmed length");
   cov_burst_gap: cover property (r.state == hcr_pkg::hcr_st_gap);
   cov_done: cover property (enable_i && $fell(busy_o));
endmodule : hcr_dma_engine
`default_nettype wire

// *** rtl/hcr_regs.sv ***
// identity, scratch, software reset and dma set-up registers
`timescale 1ns/1ps
`default_nettype none
`include "hcr_params.svh"
// Notes on behaviour
// - read-only identity: version high, identifier low
// - scratch word resets zero, echoes last write
// - bit one pulses host-register-only reset
// - bit zero resets all registers; zero nothing
// - config bits 31..8 hold byte count
// - bursts per count depend on bus width
// - burst field: 1, 4, 8, 16 cycles
// - bit one enables/terminates, bit zero direction
// - width setting: zero 16-bit, one 32-bit
// - request output polarity follows its setting
// - acknowledge input polarity follows its setting
module hcr_regs #(
   parameter int          ADDR_W            = 16,
   parameter logic [15:0] HW_VERSION        = `HCR_HW_VERSION,
   parameter logic [15:0] DEVICE_IDENTIFIER = `HCR_DEVICE_ID
) (
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   // processor register port
   input  wire logic              cs_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [31:0]       wdata_i,
   output logic [31:0]            rdata_o,
   // mode settings held elsewhere
   input  wire logic              bus_width_32_i,
   input  wire logic              request_polarity_i,
   input  wire logic              acknowledge_polarity_i,
   // dma handshake pins
   input  wire logic              transfer_ack_line_i,
   output logic                   transfer_request_line_o,
   // reset commands and dma status
   output logic                   host_regs_soft_reset_o,
   output logic                   all_regs_soft_reset_o,
   output logic                   dma_read_o,
   output logic                   dma_busy_o
);
   hcr_pkg::hcr_regs_t r;
   hcr_pkg::hcr_regs_t next_r;
   logic [15:0]        ofs;
   logic               wr_acc;
   logic               rd_acc;

   assign ofs    = 16'(addr_i);
   assign wr_acc = cs_i && wr_i;
   assign rd_acc = cs_i && rd_i && !wr_i;

   always_comb begin
      next_r           = r;
      next_r.hc_pulse  = 1'b0;
      next_r.all_pulse = 1'b0;
      next_r.start     = 1'b0;
      next_r.rdata     = `HCR_RST_WORD;
      if (rd_acc) begin
         case (ofs)
            `HCR_OFS_IDENTITY: next_r.rdata = {HW_VERSION, DEVICE_IDENTIFIER};
            `HCR_OFS_SCRATCH:  next_r.rdata = r.scratch;
            `HCR_OFS_SWRESET: begin
               next_r.rdata[`HCR_SWR_HC_BIT]  = r.hc_pulse;
               next_r.rdata[`HCR_SWR_ALL_BIT] = r.all_pulse;
            end
            `HCR_OFS_DMACFG: begin
               next_r.rdata[`HCR_CFG_CNT_HI:`HCR_CFG_CNT_LO]     = r.count;
               next_r.rdata[`HCR_CFG_BURST_HI:`HCR_CFG_BURST_LO] = r.burst;
               next_r.rdata[`HCR_CFG_EN_BIT]                     = r.en;
               next_r.rdata[`HCR_CFG_DIR_BIT]                    = r.dir;
            end
            default: next_r.rdata = `HCR_RST_WORD;
         endcase
      end
      if (wr_acc) begin
         case (ofs)
            `HCR_OFS_SCRATCH: next_r.scratch = wdata_i;
            `HCR_OFS_SWRESET: begin
               // reserved bits are ignored; software keeps them zero
               if (wdata_i[`HCR_SWR_HC_BIT]) begin
                  next_r.hc_pulse = 1'b1;
               end
               if (wdata_i[`HCR_SWR_ALL_BIT]) begin
                  next_r.scratch   = `HCR_RST_WORD;
                  next_r.count     = `HCR_RST_COUNT;
                  next_r.burst     = `HCR_RST_BURST;
                  next_r.en        = 1'b0;
                  next_r.dir       = 1'b0;
                  next_r.hc_pulse  = 1'b1;
                  next_r.all_pulse = 1'b1;
               end
            end
            `HCR_OFS_DMACFG: begin
               next_r.count = wdata_i[`HCR_CFG_CNT_HI:`HCR_CFG_CNT_LO];
               next_r.burst = wdata_i[`HCR_CFG_BURST_HI:`HCR_CFG_BURST_LO];
               next_r.en    = wdata_i[`HCR_CFG_EN_BIT];
               next_r.dir   = wdata_i[`HCR_CFG_DIR_BIT];
               next_r.start = wdata_i[`HCR_CFG_EN_BIT];
            end
            default: next_r.start = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // a rewrite with the enable set starts only an idle engine; a running count is kept
   hcr_dma_engine u_dma (
      .sys_clk_i              (sys_clk_i),
      .rst_i                  (rst_i),
      .soft_clear_i           (r.all_pulse),
      .start_i                (r.start),
      .enable_i               (r.en),
      .byte_count_i           (r.count),
      .burst_sel_i            (r.burst),
      .bus_width_32_i         (bus_width_32_i),
      .request_polarity_i     (request_polarity_i),
      .acknowledge_polarity_i (acknowledge_polarity_i),
      .transfer_ack_line_i    (transfer_ack_line_i),
      .transfer_request_line_o(transfer_request_line_o),
      .busy_o                 (dma_busy_o)
   );

   assign rdata_o                = r.rdata;
   assign host_regs_soft_reset_o = r.hc_pulse;
   assign all_regs_soft_reset_o  = r.all_pulse;
   assign dma_read_o             = r.dir;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   chk_id_readback: assert property (
      rd_acc && ofs == `HCR_OFS_IDENTITY |=> rdata_o == {HW_VERSION, DEVICE_IDENTIFIER})
      else $error("identity word wrong");
   chk_scratch_echo: assert property (
      wr_acc && ofs == `HCR_OFS_SCRATCH ##1 rd_acc && ofs == `HCR_OFS_SCRATCH
      |=> rdata_o == $past(wdata_i, 2))
      else $error("scratch did not echo write");
   chk_hc_pulse_once: assert property (
      wr_acc && ofs == `HCR_OFS_SWRESET && wdata_i[`HCR_SWR_HC_BIT]
      |=> host_regs_soft_reset_o ##1 !host_regs_soft_reset_o || $past(wr_acc))
      else $error("host reset pulse wrong");
   chk_hc_keeps_regs: assert property (
      wr_acc && ofs == `HCR_OFS_SWRESET && !wdata_i[`HCR_SWR_ALL_BIT]
      |=> $stable(r.scratch) && $stable(r.count) && !all_regs_soft_reset_o)
      else $error("host-only reset touched other registers");
   chk_all_clears: assert property (
      wr_acc && ofs == `HCR_OFS_SWRESET && wdata_i[`HCR_SWR_ALL_BIT]
      |=> all_regs_soft_reset_o && r.scratch == `HCR_RST_WORD && !r.en && !dma_read_o)
      else $error("reset all did not clear registers");
   chk_zero_no_reset: assert property (
      wr_acc && ofs == `HCR_OFS_SWRESET && wdata_i[`HCR_SWR_HC_BIT:`HCR_SWR_ALL_BIT] == 2'h0
      |=> !host_regs_soft_reset_o && !all_regs_soft_reset_o)
      else $error("reset fired on zero write");
   chk_cfg_fields: assert property (
      wr_acc && ofs == `HCR_OFS_DMACFG ##1 rd_acc && ofs == `HCR_OFS_DMACFG
      |=> rdata_o == {$past(wdata_i[31:8], 2), 4'h0, $past(wdata_i[3:0], 2)})
      else $error("dma config readback wrong");
   chk_reset_reads_zero: assert property (
      rd_acc && ofs == `HCR_OFS_SWRESET && !r.hc_pulse && !r.all_pulse |=> rdata_o == `HCR_RST_WORD)
      else $error("reset register not zero after reset");

   chk_id_write_ignored: assert property (
      wr_acc && ofs == `HCR_OFS_IDENTITY
      |=> $stable(r.scratch) && !host_regs_soft_reset_o && !all_regs_soft_reset_o)
      else $error("identity write had an effect");
   chk_pulse_needs_write: assert property (
      !(wr_acc && ofs == `HCR_OFS_SWRESET)
      |=> !host_regs_soft_reset_o && !all_regs_soft_reset_o)
      else $error("reset pulse without a reset write");
   chk_all_with_hc: assert property (
      all_regs_soft_reset_o |-> host_regs_soft_reset_o)
      else $error("reset all did not reset host registers");
   chk_hc_only: assert property (
      wr_acc && ofs == `HCR_OFS_SWRESET && wdata_i[`HCR_SWR_HC_BIT]
      && !wdata_i[`HCR_SWR_ALL_BIT] |=> host_regs_soft_reset_o && !all_regs_soft_reset_o)
      else $error("host-only reset pulses wrong");
   chk_scratch_hold: assert property (
      !wr_acc |=> $stable(r.scratch))
      else $error("scratch changed without a write");
   chk_cfg_hold: assert property (
      !wr_acc |=> $stable(r.count) && $stable(r.burst) && $stable(r.en) && $stable(r.dir))
      else $error("dma config changed without a write");
   chk_count_loads: assert property (
      wr_acc && ofs == `HCR_OFS_DMACFG
      |=> r.count == $past(wdata_i[`HCR_CFG_CNT_HI:`HCR_CFG_CNT_LO]))
      else $error("byte count not taken from write");
   chk_burst_loads: assert property (
      wr_acc && ofs == `HCR_OFS_DMACFG
      |=> r.burst == $past(wdata_i[`HCR_CFG_BURST_HI:`HCR_CFG_BURST_LO]))
      else $error("burst field not taken from write");
   chk_dir_follows: assert property (
      wr_acc && ofs == `HCR_OFS_DMACFG
      |=> dma_read_o == $past(wdata_i[`HCR_CFG_DIR_BIT]))
      else $error("direction output wrong");
   chk_enable_starts: assert property (
      wr_acc && ofs == `HCR_OFS_DMACFG && wdata_i[`HCR_CFG_EN_BIT] && !dma_busy_o && !r.start
      && wdata_i[`HCR_CFG_CNT_HI:`HCR_CFG_CNT_LO] != `HCR_RST_COUNT |-> ##2 dma_busy_o)
      else $error("enabled transfer did not start");
   chk_busy_needs_en: assert property (
      dma_busy_o |-> $past(r.en))
      else $error("transfer busy while terminated");
   chk_req_idle_level: assert property (
      !dma_busy_o && $stable(request_polarity_i)
      |-> transfer_request_line_o != request_polarity_i)
      else $error("request line active while idle");

   cov_reset_all: cover property (all_regs_soft_reset_o);
   cov_dma_start: cover property (r.start ##1 dma_busy_o);
   cov_id_read: cover property (rd_acc && ofs == `HCR_OFS_IDENTITY);
endmodule : hcr_regs
`default_nettype wire

// *** verif/hcr_ack_model.sv ***
// dma acknowledge responder standing in for the host dma controller
`timescale 1ns/1ps
`default_nettype none
module hcr_ack_model (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // settings
   input  wire logic req_pol_i,
   input  wire logic ack_pol_i,
   input  wire logic slow_i,
   // handshake pins
   input  wire logic req_i,
   output logic      ack_o
);
   logic [2:0] gap;
   logic       ack;
   // one ack per beat, spaced so no stale ack is still in flight when a burst ends
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || ack) begin
         gap <= 3'h0;
      end else if (gap != 3'h7) begin
         gap <= gap + 3'h1;
      end
      ack <= !rst_i && !ack && (req_i == req_pol_i) && (gap >= (slow_i ? 3'h5 : 3'h3));
   end
   assign ack_o = ack ~^ ack_pol_i;
endmodule : hcr_ack_model
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the identity, reset and dma set-up registers
`timescale 1ns/1ps
`default_nettype none
`include "hcr_params.svh"
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cs = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000, rdata, q;
   logic        w32 = 1'b1, rp = 1'b1, ap = 1'b1, slow = 1'b0;
   logic        ack, req, hpls, apls, dread, busy;
   logic        act_q = 1'b0;
   int          mismatches = 0, comparisons = 0, bursts = 0, acks = 0;

   always #12.5 clk = ~clk;

   hcr_regs i_hcr_regs (.sys_clk_i(clk), .rst_i(rst), .cs_i(cs), .wr_i(wr), .rd_i(rd),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .bus_width_32_i(w32),
      .request_polarity_i(rp), .acknowledge_polarity_i(ap), .transfer_ack_line_i(ack),
      .transfer_request_line_o(req), .host_regs_soft_reset_o(hpls),
      .all_regs_soft_reset_o(apls), .dma_read_o(dread), .dma_busy_o(busy));
   hcr_ack_model i_hcr_ack_model (.sys_clk_i(clk), .rst_i(rst), .req_pol_i(rp),
      .ack_pol_i(ap), .slow_i(slow), .req_i(req), .ack_o(ack));

   // bursts seen as rising edges of the active request level
   // sampled on the falling edge, clear of the edge that launches request and ack
   always @(negedge clk) begin
      if ((req === rp) && !act_q) bursts++;
      if (ack === ap) acks++;
      act_q <= (req === rp);
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      #1 cs = 1'b1;
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1 cs = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      q = rdata;
   endtask : acc

   // write then read with no idle cycle between, as the port allows
   task automatic wr_rd(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      #1 cs = 1'b1;
      wr = 1'b1;
      rd = 1'b0;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1 wr = 1'b0;
      rd = 1'b1;
      @(posedge clk);
      #1 cs = 1'b0;
      rd = 1'b0;
      q = rdata;
   endtask : wr_rd

   task automatic t_regs();
      acc(1'b1, `HCR_OFS_IDENTITY, 32'hffff_ffff);
      acc(1'b0, `HCR_OFS_IDENTITY, 32'h0);
      chk("identity", {`HCR_HW_VERSION, `HCR_DEVICE_ID}, q);
      acc(1'b0, `HCR_OFS_SCRATCH, 32'h0);
      chk("scratch reset", 32'h0, q);
      wr_rd(`HCR_OFS_SCRATCH, 32'ha5c3_0f96);
      chk("scratch", 32'ha5c3_0f96, q);
      // enable bit clear and zero count keep the engine idle while the fields are read back
      wr_rd(`HCR_OFS_DMACFG, 32'h0000_000d);
      chk("dma cfg", 32'h0000_000d, q);
      chk("dma read", 32'h1, {31'h0, dread});
      chk("busy zero count", 32'h0, {31'h0, busy});
      acc(1'b0, 16'h0334, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("test regs done");
   endtask : t_regs

   task automatic t_swr();
      acc(1'b1, `HCR_OFS_SWRESET, 32'h0000_0002);
      chk("host pulse", 32'h2, {30'h0, hpls, apls});
      @(posedge clk);
      #1 chk("host pulse end", 32'h0, {31'h0, hpls});
      acc(1'b0, `HCR_OFS_SCRATCH, 32'h0);
      chk("scratch kept", 32'ha5c3_0f96, q);
      acc(1'b0, `HCR_OFS_SWRESET, 32'h0);
      chk("reset reg", 32'h0, q);
      acc(1'b1, `HCR_OFS_SWRESET, 32'h0);
      chk("no pulse", 32'h0, {30'h0, hpls, apls});
      acc(1'b1, `HCR_OFS_DMACFG, 32'h0000_4002);
      acc(1'b1, `HCR_OFS_SWRESET, 32'h0000_0001);
      chk("both pulses", 32'h3, {30'h0, hpls, apls});
      repeat (2) @(posedge clk);
      #1 chk("busy after reset", 32'h0, {31'h0, busy});
      acc(1'b0, `HCR_OFS_SCRATCH, 32'h0);
      chk("scratch cleared", 32'h0, q);
      acc(1'b0, `HCR_OFS_DMACFG, 32'h0);
      chk("cfg cleared", 32'h0, q);
      $display("test soft reset done");
   endtask : t_swr

   task automatic t_dma(input logic w, input logic [1:0] bl, input logic p);
      int beats;
      int n;
      w32 = w;
      rp = p;
      ap = !p;
      slow = p;
      beats = w ? 10 : 20;
      n = 1 << ((bl == 2'h0) ? 0 : bl + 1);
      repeat (3) @(posedge clk);
      #1 chk("request idle", {31'h0, !p}, {31'h0, req});
      bursts = 0;
      acks = 0;
      acc(1'b1, `HCR_OFS_DMACFG, {24'd40, 4'h0, bl, 2'b10});
      repeat (2) @(posedge clk);
      #1 chk("busy start", 32'h1, {31'h0, busy});
      for (int k = 0; k < 2000 && busy !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      chk("busy done", 32'h0, {31'h0, busy});
      chk("request off", {31'h0, !p}, {31'h0, req});
      chk("bursts", (beats + n - 1) / n, bursts);
      chk("acks", beats, acks);
      $display("test dma width %0d burst %0d done", w, bl);
   endtask : t_dma

   task automatic t_abort();
      acc(1'b1, `HCR_OFS_DMACFG, 32'h0010_0006);
      repeat (20) @(posedge clk);
      #1 chk("busy running", 32'h1, {31'h0, busy});
      acc(1'b1, `HCR_OFS_DMACFG, 32'h0010_0004);
      repeat (2) @(posedge clk);
      #1 chk("abandoned", {30'h0, !rp, 1'b0}, {30'h0, req, busy});
      $display("test abort done");
   endtask : t_abort

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      t_regs();
      t_swr();
      for (int w = 0; w < 2; w++) begin
         for (int b = 0; b < 4; b++) begin
            t_dma(w[0], b[1:0], b[0] ^ w[0]);
         end
      end
      t_abort();
      close_out();
   end

   // the whole run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
endmodule : tb
`default_nettype wire
